// >>> hw/csl_lamp_ctrl.sv
/*
 * Status lamp driver for one isolated CAN port: a usage lamp and a bus
 * activity lamp, each red or green, chosen from host session state, port
 * power, frame traffic and the controller's fault confinement state.
 * Assumes frame pulses and fault state come from logic on clk, the power
 * good level comes from a pin, and software uses the plain register port.
 */
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Contract
// R01 - Two lamps per port, each able to light red or green.
// R02 - First lamp mainly shows whether a host session uses the port.
// R03 - Second lamp mainly shows traffic activity on the attached bus.
// R04 - Blink toggles at a fixed rate of several times per second.
// R05 - Activity flashes pseudo-randomly from a traffic-gated shift register.
// R06 - No open session leaves both lamps dark.
// R07 - Session open, powered, no traffic: first solid green, second dark.
// R08 - Traffic and error active: first solid green, second green activity.
// R09 - Traffic and error passive: first solid green, second red activity.
// R10 - Activity ends one second after the last frame; each frame restarts it.
// R11 - Bus off while running: first solid green, second solid red.
// R12 - Identification request blinks both lamps green over everything else.
// R13 - Catastrophic error blinks both red, yielding only to identification.
module csl_lamp_ctrl
	import csl_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES_P = HOLD_CYCLES,
	parameter int unsigned BLINK_CYCLES_P = BLINK_CYCLES,
	parameter int unsigned ACT_STEP_CYCLES_P = ACT_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic port_power_pin,
	input wire logic tx_frame_done,
	input wire logic rx_frame_done,
	input wire logic [1:0] fault_state,
	output logic usage_lamp_green,
	output logic usage_lamp_red,
	output logic bus_activity_lamp_green,
	output logic bus_activity_lamp_red
);

	logic [3:0] ctrl;
	logic [3:0] next_ctrl;
	logic [31:0] next_rdata;
	logic power_meta;
	logic power_ok;
	logic [31:0] hold_cnt;
	logic [31:0] next_hold_cnt;
	logic hold_active;
	logic frame_seen;
	logic blink_tick;
	logic blink_phase;
	logic next_blink_phase;
	logic act_step;
	logic act_bit;
	logic act_step_gated;
	csl_mode_t mode;
	logic session_open;
	logic hw_running;
	logic identify;
	logic fatal_error;
	logic bus_off;
	logic passive;
	logic next_usage_green;
	logic next_usage_red;
	logic next_bus_green;
	logic next_bus_red;

	assign session_open = ctrl[CTRL_SESSION_BIT];
	assign hw_running = ctrl[CTRL_RUNNING_BIT];
	assign identify = ctrl[CTRL_IDENTIFY_BIT];
	assign fatal_error = ctrl[CTRL_FATAL_BIT];
	assign bus_off = fault_state[1];
	assign passive = (fault_state == FAULT_PASSIVE);
	assign frame_seen = tx_frame_done | rx_frame_done;
	assign hold_active = (hold_cnt != 32'h0);

	// Register port: writes land in the control bits, reads answer next cycle
	always_comb begin
		next_ctrl = ctrl;
		next_rdata = 32'h0;
		if (reg_write && reg_addr == CTRL_OFFSET) begin
			next_ctrl = reg_wdata[CTRL_W-1:0];
		end
		if (reg_read) begin
			unique case (reg_addr)
				CTRL_OFFSET: begin
					next_rdata = {28'h0, ctrl};
				end
				STATUS_OFFSET: begin
					next_rdata[STAT_USAGE_GREEN_BIT] = usage_lamp_green;
					next_rdata[STAT_USAGE_RED_BIT] = usage_lamp_red;
					next_rdata[STAT_BUS_GREEN_BIT] = bus_activity_lamp_green;
					next_rdata[STAT_BUS_RED_BIT] = bus_activity_lamp_red;
					next_rdata[STAT_HOLD_BIT] = hold_active;
					next_rdata[STAT_FAULT_LSB +: 2] = fault_state;
					next_rdata[STAT_POWER_BIT] = power_ok;
					next_rdata[STAT_MODE_LSB +: 3] = mode;
				end
				default: begin
					next_rdata = 32'h0; // Unmapped offsets read as zero
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= CTRL_RESET;
			reg_rdata <= 32'h0;
		end else begin
			ctrl <= next_ctrl;
			reg_rdata <= next_rdata;
		end
	end

	// Power good arrives from a pin, so it is resynchronised first
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			power_meta <= 1'b0;
			power_ok <= 1'b0;
		end else begin
			power_meta <= port_power_pin;
			power_ok <= power_meta;
		end
	end

	// Activity hold: reload on any frame, count down to dark
	always_comb begin
		next_hold_cnt = hold_cnt;
		if (frame_seen) begin
			next_hold_cnt = 32'(HOLD_CYCLES_P); // R10
		end else if (hold_active) begin
			next_hold_cnt = hold_cnt - 32'h1; // R10
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_cnt <= 32'h0;
		end else begin
			hold_cnt <= next_hold_cnt;
		end
	end

	// Blink rate divider runs free so both lamps blink in step
	csl_tick_div #(
		.PERIOD(BLINK_CYCLES_P)
	) u_blink_div (
		.clk(clk),
		.reset_n(reset_n),
		.enable(1'b1),
		.tick(blink_tick)
	);

	always_comb begin
		next_blink_phase = blink_phase;
		if (blink_tick) begin
			next_blink_phase = !blink_phase; // R04
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			blink_phase <= 1'b0;
		end else begin
			blink_phase <= next_blink_phase;
		end
	end

	// Pattern steps only while traffic is held, so an idle bus freezes it
	csl_tick_div #(
		.PERIOD(ACT_STEP_CYCLES_P)
	) u_act_div (
		.clk(clk),
		.reset_n(reset_n),
		.enable(hold_active),
		.tick(act_step)
	);

	// A tick already in flight when the hold ends must not step the pattern
	assign act_step_gated = act_step && hold_active; // R05

	csl_lfsr u_act_lfsr (
		.clk(clk),
		.reset_n(reset_n),
		.step(act_step_gated), // R05
		.pattern_bit(act_bit)
	);

	// Priority: identify, fatal, no session, bus off, traffic, idle
	always_comb begin
		if (identify) begin
			mode = MODE_IDENT; // R12
		end else if (fatal_error) begin
			mode = MODE_FATAL; // R13
		end else if (!session_open) begin
			mode = MODE_DARK; // R06
		end else if (hw_running && bus_off) begin
			mode = MODE_BUS_OFF; // R11
		end else if (hold_active) begin
			mode = MODE_TRAFFIC; // R08 R09
		end else if (power_ok) begin
			mode = MODE_IDLE; // R07
		end else begin
			mode = MODE_DARK; // Unpowered port shows nothing
		end
	end

	// Colour and pattern per mode; outputs are registered to stay glitch free
	always_comb begin
		next_usage_green = 1'b0;
		next_usage_red = 1'b0;
		next_bus_green = 1'b0;
		next_bus_red = 1'b0;
		unique case (mode)
			MODE_IDENT: begin
				next_usage_green = blink_phase; // R12
				next_bus_green = blink_phase;
			end
			MODE_FATAL: begin
				next_usage_red = blink_phase; // R13
				next_bus_red = blink_phase;
			end
			MODE_BUS_OFF: begin
				next_usage_green = 1'b1; // R11
				next_bus_red = 1'b1;
			end
			MODE_TRAFFIC: begin
				next_usage_green = 1'b1; // R02
				next_bus_green = !passive && act_bit; // R08 R03
				next_bus_red = passive && act_bit; // R09
			end
			MODE_IDLE: begin
				next_usage_green = 1'b1; // R07
			end
			MODE_DARK: begin
				next_usage_green = 1'b0; // R06
			end
			default: begin
				next_usage_green = 1'b0;
			end
		endcase
	end

	// Two bicolour lamps, one drive line per colour
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			usage_lamp_green <= 1'b0;
			usage_lamp_red <= 1'b0;
			bus_activity_lamp_green <= 1'b0;
			bus_activity_lamp_red <= 1'b0;
		end else begin
			usage_lamp_green <= next_usage_green; // R01
			usage_lamp_red <= next_usage_red;
			bus_activity_lamp_green <= next_bus_green;
			bus_activity_lamp_red <= next_bus_red;
		end
	end

	// Checks on the lamp outputs, hold counter, blink phase and activity pattern, all in the one clock domain
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence seq_frame;
		frame_seen;
	endsequence

	sequence seq_hold_reloaded;
		hold_cnt == 32'(HOLD_CYCLES_P);
	endsequence

	sequence seq_last_count;
		hold_cnt == 32'h1 && !frame_seen;
	endsequence

	chk_ident_green_blink: assert property ( // R12
		identify |=> !usage_lamp_red && !bus_activity_lamp_red
			&& usage_lamp_green == $past(blink_phase)
			&& bus_activity_lamp_green == $past(blink_phase))
		else $error("identify must blink both lamps green");

	chk_fatal_red_blink: assert property ( // R13
		!identify && fatal_error |=> !usage_lamp_green && !bus_activity_lamp_green
			&& usage_lamp_red == $past(blink_phase)
			&& bus_activity_lamp_red == $past(blink_phase))
		else $error("fatal error must blink both lamps red");

	chk_no_session_dark: assert property ( // R06
		!identify && !fatal_error && !session_open |=> !usage_lamp_green
			&& !usage_lamp_red && !bus_activity_lamp_green && !bus_activity_lamp_red)
		else $error("lamps must be dark without a session");

	chk_idle_solid_green: assert property ( // R07
		mode == MODE_IDLE |-> session_open && power_ok && !hold_active
			##1 usage_lamp_green && !usage_lamp_red
			&& !bus_activity_lamp_green && !bus_activity_lamp_red)
		else $error("idle session must show solid green and dark bus lamp");

	chk_active_green_flicker: assert property ( // R08
		mode == MODE_TRAFFIC && fault_state == FAULT_ACTIVE |=> usage_lamp_green
			&& !bus_activity_lamp_red && bus_activity_lamp_green == $past(act_bit))
		else $error("error active traffic must flicker green");

	chk_passive_red_flicker: assert property ( // R09
		mode == MODE_TRAFFIC && fault_state == FAULT_PASSIVE |=> usage_lamp_green
			&& !bus_activity_lamp_green && bus_activity_lamp_red == $past(act_bit))
		else $error("error passive traffic must flicker red");

	chk_bus_off_red: assert property ( // R11
		!identify && !fatal_error && session_open && hw_running && bus_off
			|=> usage_lamp_green && bus_activity_lamp_red && !bus_activity_lamp_green)
		else $error("bus off must show solid green and solid red");

	chk_hold_restart: assert property ( // R10
		seq_frame |=> seq_hold_reloaded ##1 hold_active)
		else $error("a frame must restart the one second hold");

	chk_hold_expire: assert property ( // R10
		seq_last_count |=> !hold_active ##1 ($past(frame_seen) || !hold_active))
		else $error("hold must end exactly after its count");

	chk_blink_toggle: assert property ( // R04
		blink_tick |=> blink_phase != $past(blink_phase))
		else $error("blink phase must toggle on every divider tick");

	chk_flicker_frozen: assert property ( // R05
		!hold_active && !frame_seen |=> $stable(act_bit))
		else $error("activity pattern must not step without traffic");

	chk_one_colour: assert property ( // R01
		!(usage_lamp_green && usage_lamp_red)
			&& !(bus_activity_lamp_green && bus_activity_lamp_red))
		else $error("a lamp must never drive both colours at once");

	chk_hold_bounded: assert property ( // R10
		hold_cnt <= 32'(HOLD_CYCLES_P))
		else $error("hold count must never exceed one second");

endmodule

`default_nettype wire

// >>> hw/csl_lfsr.sv
/*
 * Sixteen-bit Galois shift register for the pseudo-random activity flicker.
 * Assumes step is a one-cycle enable from the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module csl_lfsr
	import csl_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic step,
	output logic pattern_bit
);

	logic [15:0] state;
	logic [15:0] next_state;

	// Shift right and fold the taps in; a nonzero seed never reaches all zeros
	always_comb begin
		next_state = state;
		if (step) begin
			next_state = {1'b0, state[15:1]} ^ (state[0] ? LFSR_TAPS : 16'h0000);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= LFSR_SEED;
		end else begin
			state <= next_state;
		end
	end

	assign pattern_bit = state[0]; // Straight from a flip-flop

endmodule

`default_nettype wire

// >>> hw/csl_tick_div.sv
/*
 * Free-running divider producing a one-cycle enable pulse every PERIOD cycles.
 * Assumes PERIOD of at least one; a low enable holds the count at zero.
 */
`timescale 1ns/100ps
`default_nettype none

module csl_tick_div
	import csl_pkg::*;
#(
	parameter int unsigned PERIOD = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic enable,
	output logic tick
);

	logic [31:0] count;
	logic [31:0] next_count;
	logic next_tick;

	// Count up and wrap; restarting on enable keeps the first step a full period
	always_comb begin
		next_count = count;
		next_tick = 1'b0;
		if (!enable) begin
			next_count = 32'h0;
		end else if (count == 32'(PERIOD - 1)) begin
			next_count = 32'h0;
			next_tick = 1'b1;
		end else begin
			next_count = count + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 32'h0;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end

endmodule

`default_nettype wire

// >>> include/csl_pkg.sv
/*
 * Constants and types shared by the CAN port status lamp driver.
 * Assumes one 100 MHz system clock; all times become cycle counts here.
 */
package csl_pkg;

	// Clock
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned NS_PER_MS = 1000000;

	// Activity hold after the last frame
	localparam int unsigned HOLD_TIME_MS = 1000;
	localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

	// Blink half period, giving four on/off cycles per second
	localparam int unsigned BLINK_TIME_MS = 125;
	localparam int unsigned BLINK_CYCLES = BLINK_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

	// Step interval of the pseudo-random activity pattern
	localparam int unsigned ACT_STEP_TIME_MS = 40;
	localparam int unsigned ACT_STEP_CYCLES = ACT_STEP_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

	// Register port
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;

	// Control register fields
	localparam int unsigned CTRL_W = 4;
	localparam int unsigned CTRL_SESSION_BIT = 0;
	localparam int unsigned CTRL_RUNNING_BIT = 1;
	localparam int unsigned CTRL_IDENTIFY_BIT = 2;
	localparam int unsigned CTRL_FATAL_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// Status register fields
	localparam int unsigned STAT_USAGE_GREEN_BIT = 0;
	localparam int unsigned STAT_USAGE_RED_BIT = 1;
	localparam int unsigned STAT_BUS_GREEN_BIT = 2;
	localparam int unsigned STAT_BUS_RED_BIT = 3;
	localparam int unsigned STAT_HOLD_BIT = 4;
	localparam int unsigned STAT_FAULT_LSB = 5;
	localparam int unsigned STAT_POWER_BIT = 7;
	localparam int unsigned STAT_MODE_LSB = 8;

	// Activity pattern generator
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;

	// Fault confinement state from the CAN controller
	typedef enum logic [1:0] {
		FAULT_ACTIVE = 2'b00,
		FAULT_PASSIVE = 2'b01,
		FAULT_BUS_OFF = 2'b10,
		FAULT_BUS_OFF_ALT = 2'b11
	} csl_fault_t;

	// Indication chosen for the two lamps, highest priority last
	typedef enum logic [2:0] {
		MODE_DARK = 3'b000,
		MODE_IDLE = 3'b001,
		MODE_TRAFFIC = 3'b010,
		MODE_BUS_OFF = 3'b011,
		MODE_FATAL = 3'b100,
		MODE_IDENT = 3'b101
	} csl_mode_t;

endpackage

// >>> tb/csl_can_model.sv
/*
 * Behavioural stand-in for the CAN controller and port supply that feed the
 * lamp driver: frame done pulses, fault confinement state and power good.
 * Assumes the bench raises each go input for one clock cycle only.
 */
`timescale 1ns/100ps
`default_nettype none

module csl_can_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic tx_go,
	input wire logic rx_go,
	input wire logic [1:0] fault_req,
	input wire logic power_req,
	output logic tx_frame_done,
	output logic rx_frame_done,
	output logic [1:0] fault_state,
	output logic port_power_pin
);
	// Controller outputs are registered on clk, as the real controller's are
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_frame_done <= 1'b0;
			rx_frame_done <= 1'b0;
			fault_state <= 2'h0;
		end else begin
			tx_frame_done <= tx_go;
			rx_frame_done <= rx_go;
			fault_state <= fault_req;
		end
	end

	// Power good moves off the clock edge, so the design's synchroniser is exercised
	assign #3 port_power_pin = power_req;
endmodule

`default_nettype wire

// >>> tb/csl_lamp_ctrl_bench.sv
/*
 * Self-checking bench for the status lamp driver: register tasks, frame and
 * fault stimulus through the controller model, lamp pattern comparisons.
 * Assumes the shortened hold, blink and step counts set below.
 */
`timescale 1ns/100ps
`default_nettype none

module csl_lamp_ctrl_bench import csl_pkg::*; ;
	localparam int unsigned HOLD_P = 50;
	localparam int unsigned BLINK_P = 4;
	localparam int unsigned STEP_P = 3;
	logic clk, reset_n, reg_write, reg_read, tx_go, rx_go, power_req;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [1:0] fault_req;
	logic [31:0] reg_rdata;
	logic tx_frame_done, rx_frame_done, port_power_pin;
	logic [1:0] fault_state;
	logic usage_lamp_green, usage_lamp_red, bus_activity_lamp_green, bus_activity_lamp_red;
	logic [3:0] lamps;
	int n_errors = 0;
	int total_checks = 0;

	assign lamps = {bus_activity_lamp_red, bus_activity_lamp_green,
		usage_lamp_red, usage_lamp_green};

	csl_can_model csl_can_model_i (.clk(clk), .reset_n(reset_n), .tx_go(tx_go), .rx_go(rx_go),
		.fault_req(fault_req), .power_req(power_req), .tx_frame_done(tx_frame_done),
		.rx_frame_done(rx_frame_done), .fault_state(fault_state), .port_power_pin(port_power_pin));

	csl_lamp_ctrl #(.HOLD_CYCLES_P(HOLD_P), .BLINK_CYCLES_P(BLINK_P), .ACT_STEP_CYCLES_P(STEP_P))
	csl_lamp_ctrl_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.port_power_pin(port_power_pin), .tx_frame_done(tx_frame_done),
		.rx_frame_done(rx_frame_done), .fault_state(fault_state),
		.usage_lamp_green(usage_lamp_green), .usage_lamp_red(usage_lamp_red),
		.bus_activity_lamp_green(bus_activity_lamp_green),
		.bus_activity_lamp_red(bus_activity_lamp_red));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task report_and_stop();
		$display("errors %0d checks %0d", n_errors, total_checks);
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task cmp_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task cmp_lamps(input logic [3:0] exp);
		total_checks++;
		if (lamps !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: lamps %h expected %h", $time, lamps, exp);
		end
	endtask

	// Waits n edges, then lets that edge's updates settle
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there
	task reg_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		cmp_word(reg_rdata & m, exp);
	endtask

	task frame(input logic tx, input logic rx);
		@(posedge clk);
		tx_go <= tx;
		rx_go <= rx;
		@(posedge clk);
		tx_go <= 1'b0;
		rx_go <= 1'b0;
	endtask

	task set_fault(input logic [1:0] f);
		@(posedge clk);
		fault_req <= f;
	endtask

	// Usage lamp must stay solid green, bus lamp flickers in one colour only
	task act_check(input logic red);
		int changes;
		logic prev;
		logic cur;
		changes = 0;
		prev = red ? bus_activity_lamp_red : bus_activity_lamp_green;
		for (int i = 0; i < 40; i++) begin
			tick(1);
			cur = red ? bus_activity_lamp_red : bus_activity_lamp_green;
			cmp_lamps(red ? {cur, 3'b001} : {1'b0, cur, 2'b01});
			if (cur !== prev) changes++;
			prev = cur;
		end
		cmp_word(32'(changes != 0), 32'h1);
	endtask

	// Both lamps blink together; spacing of two toggles is the blink count
	task blink_check(input logic red);
		logic prev;
		logic cur;
		int last;
		int seen;
		seen = 0;
		last = 0;
		prev = red ? usage_lamp_red : usage_lamp_green;
		for (int i = 0; i < 3 * BLINK_P; i++) begin
			tick(1);
			cur = red ? usage_lamp_red : usage_lamp_green;
			cmp_lamps(red ? {cur, 1'b0, cur, 1'b0} : {1'b0, cur, 1'b0, cur});
			if (cur !== prev) begin
				if (seen == 1) cmp_word(32'(i - last), 32'(BLINK_P));
				seen++;
				last = i;
			end
			prev = cur;
		end
		cmp_word(32'(seen >= 2), 32'h1);
	endtask

	initial begin
		reset_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		tx_go = 1'b0;
		rx_go = 1'b0;
		fault_req = 2'h0;
		power_req = 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		tick(1);
		cmp_lamps(4'h0);
		reg_rd(CTRL_OFFSET, 32'h0, 32'hFFFFFFFF);
		reg_rd(8'h08, 32'h0, 32'hFFFFFFFF);
		// Session open but unpowered stays dark until power good arrives
		reg_wr(CTRL_OFFSET, 32'h1);
		tick(3);
		cmp_lamps(4'h0);
		@(posedge clk);
		power_req <= 1'b1;
		tick(5);
		cmp_lamps(4'h1);
		reg_rd(STATUS_OFFSET, 32'h181, 32'hFFFFFFFF);
		// Traffic in the error active and error passive states
		frame(1'b1, 1'b0);
		tick(2);
		act_check(1'b0);
		set_fault(2'b01);
		frame(1'b0, 1'b1);
		tick(2);
		act_check(1'b1);
		// Second frame restarts the hold, then the bus lamp goes dark
		frame(1'b1, 1'b1);
		tick(30);
		frame(1'b1, 1'b0);
		tick(40);
		reg_rd(STATUS_OFFSET, 32'h10, 32'h10);
		tick(15);
		reg_rd(STATUS_OFFSET, 32'h0, 32'h10);
		cmp_lamps(4'h1);
		// Bus off needs the running bit and outranks traffic
		reg_wr(CTRL_OFFSET, 32'hFFFFFFF3);
		reg_wr(STATUS_OFFSET, 32'hFFFFFFFF);
		reg_rd(CTRL_OFFSET, 32'h3, 32'hFFFFFFFF);
		for (int f = 2; f < 4; f++) begin
			set_fault(2'(f));
			frame(1'b1, 1'b0);
			tick(3);
			cmp_lamps(4'h9);
			reg_rd(STATUS_OFFSET, 32'(f) << STAT_FAULT_LSB, 32'h60);
		end
		reg_wr(CTRL_OFFSET, 32'h1);
		tick(HOLD_P + 5);
		cmp_lamps(4'h1);
		// Fatal over bus off, identify over fatal and over a closed session
		reg_wr(CTRL_OFFSET, 32'hB);
		tick(2);
		blink_check(1'b1);
		reg_wr(CTRL_OFFSET, 32'hF);
		tick(2);
		blink_check(1'b0);
		reg_rd(STATUS_OFFSET, 32'h500, 32'h700);
		reg_wr(CTRL_OFFSET, 32'h4);
		tick(2);
		blink_check(1'b0);
		reg_wr(CTRL_OFFSET, 32'h8);
		tick(2);
		blink_check(1'b1);
		// No session hides traffic and bus off
		reg_wr(CTRL_OFFSET, 32'h0);
		frame(1'b0, 1'b1);
		tick(3);
		cmp_lamps(4'h0);
		// Reset in mid-run clears the control register
		reg_wr(CTRL_OFFSET, 32'h3);
		tick(3);
		cmp_lamps(4'h9);
		@(posedge clk);
		reset_n <= 1'b0;
		tick(2);
		cmp_lamps(4'h0);
		@(posedge clk);
		reset_n <= 1'b1;
		tick(2);
		cmp_lamps(4'h0);
		reg_rd(CTRL_OFFSET, 32'h0, 32'hFFFFFFFF);
		report_and_stop();
	end
endmodule

`default_nettype wire
